// ==== inc/pfd_cfg.svh ====
// register map, reset values, field positions and timing of the fet driver control
// assumes a 40 MHz pclk and a 32-bit apb bus with byte addresses
`ifndef PFD_CFG_SVH
`define PFD_CFG_SVH

// apb byte offsets
`define PFD_OFF_CTRL 8'h00
`define PFD_OFF_CFG 8'h04
`define PFD_OFF_FEN 8'h08
`define PFD_OFF_BDT 8'h0c
`define PFD_OFF_PWM 8'h10
`define PFD_OFF_STAT 8'h14
`define PFD_OFF_CUR 8'h18
`define PFD_OFF_FLT1 8'h1c
`define PFD_OFF_FLT2 8'h20
`define PFD_OFF_ACC 8'h24

// control register bits
`define PFD_CTRL_LOADED 0
`define PFD_CTRL_BLK_DSG 1
`define PFD_CTRL_BLK_CHG 2
`define PFD_CTRL_FRC_DSG 3
`define PFD_CTRL_FRC_CHG 4
`define PFD_CTRL_PWM_DSG 5
`define PFD_CTRL_PWM_CHG 6

// configuration register bits
`define PFD_CFG_FRC_OK 0
`define PFD_CFG_SERIES 1
`define PFD_CFG_BD_EN 2

// reset values
`define PFD_CTRL_RST 7'h00
`define PFD_CFG_RST 3'h2
`define PFD_FEN_RST 11'h7ff
`define PFD_BDT_RST 16'h0040
`define PFD_PWM_RST 24'h8080ff

// pwm register fields
`define PFD_PWM_PER 7:0
`define PFD_PWM_DDSG 15:8
`define PFD_PWM_DCHG 23:16

// active pull-low time of the charge gate
`define PFD_CLK_NS 25
`define PFD_CHG_PULL_NS 100000
`define PFD_CHG_PULL_CYC ((`PFD_CHG_PULL_NS + `PFD_CLK_NS - 1) / `PFD_CLK_NS)

// filter shifts
`define PFD_F1_SH 1
`define PFD_F2_SH 4

`endif

// ==== inc/pfd_pkg.sv ====
// types shared by the fet driver control and its pwm generator
// assumes pfd_cfg.svh supplies every number used in logic
package pfd_pkg;

    // fault flags, same layout as the autonomous-control mask
    typedef struct packed {
        logic diag;
        logic short_circuit_discharge_fault;
        logic charge_overcurrent_fault;
        logic discharge_overcurrent_tier_two;
        logic discharge_overcurrent_tier_one;
        logic charge_undertemp_fault;
        logic charge_overtemp_fault;
        logic discharge_undertemp_fault;
        logic discharge_overtemp_fault;
        logic ov;
        logic uv;
    } pfd_fault_s;

    // charge gate driver states
    typedef enum logic [1:0] {
        CHG_HOLD = 2'b00,
        CHG_ON = 2'b01,
        CHG_PULL = 2'b10,
        CHG_FLOAT = 2'b11
    } pfd_chg_e;

    // pwm generator state
    typedef struct packed {
        logic [7:0] cnt;
    } pfd_pwm_s;

    // whole state of the control block
    typedef struct packed {
        logic [6:0] ctrl;
        logic [2:0] cfg;
        logic [10:0] fen;
        logic [15:0] bdt;
        logic [23:0] pwm;
        logic [11:0] sync1;
        logic [11:0] sync2;
        logic dsg_q;
        pfd_chg_e chg_st;
        logic [11:0] pull_cnt;
        logic signed [15:0] cur;
        logic signed [15:0] flt1;
        logic signed [15:0] flt2;
        logic signed [31:0] acc;
    } pfd_state_s;

endpackage

// ==== rtl/pfd_fet_ctrl.sv ====
// charge and discharge protection fet driver control with apb registers
// assumes fault flags and charger detect arrive asynchronously,
// coulomb counter samples arrive on pclk with a one-cycle valid strobe
//
// Operation
// - discharge gate high unless blocked, faulted, or diode-protecting
// - charge gate high unless blocked, faulted, or diode-protecting
// - force-on commands act only when configuration allows
// - mask selects faults autonomously controlling each gate
// - discharge gate low disables ocd and short protections
// - charge gate off leaves overcurrent protection alone
// - charge gate pulled low 100us, then released
// - series or parallel; diode protection series, one on
// - charging with discharge fault may turn discharge on
// - discharging with charge fault may turn charge on
// - diode decisions need current magnitude above threshold
// - pwm switching on both gates, discharge driven both ways
// - charge pwm only without a charger attached
// - positive sense differential counts as charging current
// - current values, two filters and charge integral readable
`timescale 1ns/1ps
`include "pfd_cfg.svh"

module pfd_fet_ctrl (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // protection flags, asynchronous
    input wire pfd_pkg::pfd_fault_s fault_in,
    input wire logic charger_present,
    // coulomb counter sample, pclk domain
    input wire logic signed [15:0] cc_sample,
    input wire logic cc_valid,
    // gate drivers
    output logic discharge_gate_drive,
    output logic charge_gate_drive,
    output logic charge_gate_oe_n,
    // discharge overcurrent and short-circuit protection enable
    output logic dsg_ocd_enable
);

    pfd_pkg::pfd_state_s s_reg; // all state
    pfd_pkg::pfd_state_s s_next; // its next value

    ////////////////////////////////////////////////////////////////////////
    // decoded controls

    logic loaded; // configuration has been loaded
    logic frc_ok; // forcing permitted
    logic series; // series fet arrangement
    logic bd_en; // body-diode protection enabled
    logic wr; // apb write in access phase
    logic rd_hit; // address decodes to a register

    assign loaded = s_reg.ctrl[`PFD_CTRL_LOADED];
    assign frc_ok = s_reg.cfg[`PFD_CFG_FRC_OK];
    assign series = s_reg.cfg[`PFD_CFG_SERIES];
    assign bd_en = s_reg.cfg[`PFD_CFG_BD_EN];
    assign wr = psel & penable & pwrite;

    ////////////////////////////////////////////////////////////////////////
    // fault qualification

    pfd_pkg::pfd_fault_s flt; // synchronised faults
    pfd_pkg::pfd_fault_s act; // faults under autonomous control
    logic chg_att; // synchronised charger detect
    logic dsg_flt; // any discharge-inhibit fault
    logic chg_flt; // any charge-inhibit fault

    assign flt = pfd_pkg::pfd_fault_s'(s_reg.sync2[10:0]);
    assign chg_att = s_reg.sync2[11];
    // mask picks which faults may act on the gates
    assign act = flt & pfd_pkg::pfd_fault_s'(s_reg.fen);

    // discharge side faults
    assign dsg_flt = act.uv | act.discharge_overtemp_fault | act.discharge_undertemp_fault | act.discharge_overcurrent_tier_one
        | act.discharge_overcurrent_tier_two | act.short_circuit_discharge_fault | act.diag;
    // charge side faults
    assign chg_flt = act.ov | act.charge_overtemp_fault | act.charge_undertemp_fault | act.charge_overcurrent_fault
        | act.short_circuit_discharge_fault | act.diag;

    ////////////////////////////////////////////////////////////////////////
    // body-diode protection

    logic [16:0] cur_abs; // current magnitude, one bit wider for -32768
    logic over_thr; // magnitude above threshold
    logic charging; // positive sample means charging
    logic dischg; // negative sample means discharging
    logic bd_gate; // decisions allowed at all
    logic dsg_base; // discharge wanted by block and faults
    logic chg_base; // charge wanted by block and faults
    logic bd_dsg; // diode protection turns discharge on
    logic bd_chg; // diode protection turns charge on

    // sign follows the sense pins: positive is charge current
    assign charging = (s_reg.cur > 16'sh0000);
    assign dischg = s_reg.cur[15];
    assign cur_abs = dischg ? (17'h00000 - {s_reg.cur[15], s_reg.cur})
        : {1'b0, s_reg.cur};
    assign over_thr = (cur_abs > {1'b0, s_reg.bdt});
    // only series fets make a body diode to protect
    assign bd_gate = loaded & series & bd_en & over_thr;

    assign dsg_base = ~s_reg.ctrl[`PFD_CTRL_BLK_DSG] & ~dsg_flt;
    assign chg_base = ~s_reg.ctrl[`PFD_CTRL_BLK_CHG] & ~chg_flt;

    // only while exactly one driver would be on
    assign bd_dsg = bd_gate & charging & dsg_flt
        & chg_base & ~dsg_base;
    assign bd_chg = bd_gate & dischg & chg_flt
        & dsg_base & ~chg_base;

    ////////////////////////////////////////////////////////////////////////
    // gate requests

    logic frc_dsg; // effective discharge force
    logic frc_chg; // effective charge force
    logic dsg_want; // discharge requested
    logic chg_want; // charge requested
    logic dsg_pwm_run; // discharge switching active
    logic chg_pwm_run; // charge switching active
    logic dsg_ph; // discharge pwm phase
    logic chg_ph; // charge pwm phase
    logic dsg_on; // discharge gate next level
    logic chg_on; // charge gate next level

    // force ignored unless configuration permits, and before load
    assign frc_dsg = loaded & frc_ok & s_reg.ctrl[`PFD_CTRL_FRC_DSG];
    assign frc_chg = loaded & frc_ok & s_reg.ctrl[`PFD_CTRL_FRC_CHG];

    assign dsg_want = loaded & (dsg_base | frc_dsg | bd_dsg);
    assign chg_want = loaded & (chg_base | frc_chg | bd_chg);

    // switching limits average current on both gates
    assign dsg_pwm_run = loaded & s_reg.ctrl[`PFD_CTRL_PWM_DSG];
    // with a charger attached the gate follows its request without switching
    assign chg_pwm_run = loaded & s_reg.ctrl[`PFD_CTRL_PWM_CHG]
        & ~chg_att;

    // discharge pwm phase
    pfd_pwm #(
        .W(8)
    ) u_pwm_dsg (
        .pclk(pclk),
        .presetn(presetn),
        .run(dsg_pwm_run),
        .period(s_reg.pwm[`PFD_PWM_PER]),
        .duty(s_reg.pwm[`PFD_PWM_DDSG]),
        .phase(dsg_ph)
    );

    // charge pwm phase
    pfd_pwm #(
        .W(8)
    ) u_pwm_chg (
        .pclk(pclk),
        .presetn(presetn),
        .run(chg_pwm_run),
        .period(s_reg.pwm[`PFD_PWM_PER]),
        .duty(s_reg.pwm[`PFD_PWM_DCHG]),
        .phase(chg_ph)
    );

    assign dsg_on = dsg_want & (~dsg_pwm_run | dsg_ph);
    assign chg_on = chg_want & (~chg_pwm_run | chg_ph);

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        s_next = s_reg;
        // register writes, taken in the access phase
        if (wr) begin
            if (paddr == `PFD_OFF_CTRL) begin
                s_next.ctrl = pwdata[6:0];
            end else if (paddr == `PFD_OFF_CFG) begin
                s_next.cfg = pwdata[2:0];
            end else if (paddr == `PFD_OFF_FEN) begin
                s_next.fen = pwdata[10:0];
            end else if (paddr == `PFD_OFF_BDT) begin
                s_next.bdt = pwdata[15:0];
            end else if (paddr == `PFD_OFF_PWM) begin
                s_next.pwm = pwdata[23:0];
            end
        end
        // two-flop synchroniser for flags and charger detect
        s_next.sync1 = {charger_present, fault_in};
        s_next.sync2 = s_reg.sync1;
        // current sample, two filters and charge integral
        if (cc_valid) begin
            s_next.cur = cc_sample;
            s_next.flt1 = s_reg.flt1
                + ((cc_sample - s_reg.flt1) >>> `PFD_F1_SH);
            s_next.flt2 = s_reg.flt2
                + ((cc_sample - s_reg.flt2) >>> `PFD_F2_SH);
            s_next.acc = s_reg.acc + 32'(cc_sample);
        end
        // discharge driver drives both levels every cycle
        s_next.dsg_q = dsg_on;
        // charge driver: on, timed pull-low, then release
        if (!loaded) begin
            s_next.chg_st = pfd_pkg::CHG_HOLD;
            s_next.pull_cnt = '0;
        end else begin
            case (s_reg.chg_st)
                pfd_pkg::CHG_ON: begin
                    if (!chg_on) begin
                        s_next.chg_st = pfd_pkg::CHG_PULL;
                        s_next.pull_cnt = 12'(`PFD_CHG_PULL_CYC);
                    end
                end
                pfd_pkg::CHG_PULL: begin
                    if (chg_on) begin
                        s_next.chg_st = pfd_pkg::CHG_ON;
                    end else if (s_reg.pull_cnt == 12'h001) begin
                        s_next.chg_st = pfd_pkg::CHG_FLOAT;
                    end else begin
                        s_next.pull_cnt = s_reg.pull_cnt - 12'h001;
                    end
                end
                default: begin
                    // held or floating: leave only when turned on,
                    // or give a held gate its pull time before release
                    if (chg_on) begin
                        s_next.chg_st = pfd_pkg::CHG_ON;
                    end else if (s_reg.chg_st == pfd_pkg::CHG_HOLD) begin
                        s_next.chg_st = pfd_pkg::CHG_PULL;
                        s_next.pull_cnt = 12'(`PFD_CHG_PULL_CYC);
                    end
                end
            endcase
        end
    end

    // state register, constants only under reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.ctrl <= `PFD_CTRL_RST;
            s_reg.cfg <= `PFD_CFG_RST;
            s_reg.fen <= `PFD_FEN_RST;
            s_reg.bdt <= `PFD_BDT_RST;
            s_reg.pwm <= `PFD_PWM_RST;
            s_reg.chg_st <= pfd_pkg::CHG_HOLD;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb read mux, zero-wait answers
    always_comb begin
        prdata = 32'h0000_0000;
        rd_hit = 1'b1;
        if (paddr == `PFD_OFF_CTRL) begin
            prdata[6:0] = s_reg.ctrl;
        end else if (paddr == `PFD_OFF_CFG) begin
            prdata[2:0] = s_reg.cfg;
        end else if (paddr == `PFD_OFF_FEN) begin
            prdata[10:0] = s_reg.fen;
        end else if (paddr == `PFD_OFF_BDT) begin
            prdata[15:0] = s_reg.bdt;
        end else if (paddr == `PFD_OFF_PWM) begin
            prdata[23:0] = s_reg.pwm;
        end else if (paddr == `PFD_OFF_STAT) begin
            // driver levels, diode actions and live flags
            prdata[0] = s_reg.dsg_q;
            prdata[1] = (s_reg.chg_st == pfd_pkg::CHG_ON);
            prdata[3:2] = s_reg.chg_st;
            prdata[4] = bd_dsg;
            prdata[5] = bd_chg;
            prdata[6] = chg_att;
            prdata[7] = over_thr;
            prdata[18:8] = flt;
        end else if (paddr == `PFD_OFF_CUR) begin
            prdata = 32'(s_reg.cur);
        end else if (paddr == `PFD_OFF_FLT1) begin
            prdata = 32'(s_reg.flt1);
        end else if (paddr == `PFD_OFF_FLT2) begin
            prdata = 32'(s_reg.flt2);
        end else if (paddr == `PFD_OFF_ACC) begin
            prdata = s_reg.acc;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // no wait states; unmapped addresses report an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~rd_hit;

    ////////////////////////////////////////////////////////////////////////
    // pin outputs

    assign discharge_gate_drive = s_reg.dsg_q;
    // charge driver is active in every state but released
    assign charge_gate_drive = (s_reg.chg_st == pfd_pkg::CHG_ON);
    assign charge_gate_oe_n = (s_reg.chg_st == pfd_pkg::CHG_FLOAT);
    // protections follow the discharge pin only; charge state never
    // enters here, which keeps the charge side from touching them
    assign dsg_ocd_enable = s_reg.dsg_q;

endmodule

// ==== rtl/pfd_pwm.sv ====
// free-running pwm phase generator, one per gate driver
// assumes period and duty are stable flops on the same clock
`timescale 1ns/1ps
`include "pfd_cfg.svh"

module pfd_pwm #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    input wire logic [W-1:0] period,
    input wire logic [W-1:0] duty,
    // phase, high while the fet may conduct
    output logic phase
);

    pfd_pkg::pfd_pwm_s s_reg; // counter state
    pfd_pkg::pfd_pwm_s s_next; // its next value

    ////////////////////////////////////////////////////////////////////////
    // counter wraps at period; held at zero while idle so a new run
    // starts with an on phase whenever duty is nonzero
    always_comb begin
        s_next = s_reg;
        if (!run) begin
            s_next.cnt = '0;
        end else if (s_reg.cnt >= period) begin
            s_next.cnt = '0;
        end else begin
            s_next.cnt = s_reg.cnt + 8'h01;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // duty of zero keeps the fet off, duty above period keeps it on
    assign phase = (s_reg.cnt < duty);

endmodule

// ==== tb/pfd_fet_ctrl_properties.sv ====
// timing checks on the fet driver control ports
// assumes pclk domain only; control and config are tracked from apb writes
`timescale 1ns/1ps
`include "pfd_cfg.svh"

module pfd_fet_ctrl_properties (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // flags and current
    input wire pfd_pkg::pfd_fault_s fault_in,
    input wire logic charger_present,
    input wire logic signed [15:0] cc_sample,
    input wire logic cc_valid,
    // gates
    input wire logic discharge_gate_drive,
    input wire logic charge_gate_drive,
    input wire logic charge_gate_oe_n,
    input wire logic dsg_ocd_enable
);
    // slack of two edges for the state register and the sampling edge
    localparam int PULL_MIN = `PFD_CHG_PULL_CYC - 2;
    logic [6:0] ctrl_reg; // shadow of control
    logic [2:0] cfg_reg; // shadow of config
    logic [12:0] low_reg; // cycles the charge pin has been pulled low
    logic wr_en;

    assign wr_en = psel && penable && pwrite;

    ////////////////////////////////////////////////////////////////////////
    // shadows follow completed writes only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= 7'h00;
            cfg_reg <= 3'h2;
            low_reg <= 13'h0000;
        end else begin
            if (wr_en && paddr == `PFD_OFF_CTRL) begin
                ctrl_reg <= pwdata[6:0];
            end
            if (wr_en && paddr == `PFD_OFF_CFG) begin
                cfg_reg <= pwdata[2:0];
            end
            // saturates, so a long hold never wraps
            if (charge_gate_drive || charge_gate_oe_n) begin
                low_reg <= 13'h0000;
            end else if (low_reg != 13'h1fff) begin
                low_reg <= low_reg + 13'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // a condition must hold over the write edge and the gate edge
    sequence s_held(logic c);
        c ##1 c;
    endsequence

    a_ocd_follow: assert property (dsg_ocd_enable == discharge_gate_drive)
        else $error("ocd enable differs from discharge gate");
    a_pready_high: assert property (pready)
        else $error("pready low");
    a_unmapped_err: assert property (psel && penable && paddr > 8'h24 |->
        pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    a_not_loaded: assert property (s_held(!ctrl_reg[0]) |->
        !discharge_gate_drive && !charge_gate_drive) else $error("gate on before load");
    a_force_dsg_on: assert property (s_held(ctrl_reg[0] && ctrl_reg[3] && cfg_reg[0] &&
        !ctrl_reg[5]) |-> discharge_gate_drive) else $error("allowed force ignored");
    a_force_ignored: assert property (s_held(ctrl_reg[1] && ctrl_reg[3] && !cfg_reg[0] &&
        !cfg_reg[2]) |-> !discharge_gate_drive) else $error("force acted unallowed");
    a_block_chg: assert property (s_held(ctrl_reg[2] && !(ctrl_reg[4] && cfg_reg[0]) &&
        !cfg_reg[2]) |-> !charge_gate_drive) else $error("blocked charge gate on");
    a_pull_low: assert property ($fell(charge_gate_drive) && !ctrl_reg[6] |->
        !charge_gate_oe_n [*8]) else $error("charge pin released early");
    a_pull_time: assert property ($rose(charge_gate_oe_n) |-> low_reg >= PULL_MIN)
        else $error("charge pull-low too short");
    a_float_quiet: assert property (charge_gate_oe_n |-> !charge_gate_drive &&
        $past(ctrl_reg[0])) else $error("charge pin released while unloaded");
endmodule

bind pfd_fet_ctrl pfd_fet_ctrl_properties i_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault_in(fault_in),
    .charger_present(charger_present), .cc_sample(cc_sample), .cc_valid(cc_valid),
    .discharge_gate_drive(discharge_gate_drive), .charge_gate_drive(charge_gate_drive),
    .charge_gate_oe_n(charge_gate_oe_n), .dsg_ocd_enable(dsg_ocd_enable));

// ==== tb/pfd_fet_ctrl_tb_top.sv ====
// self-checking bench of the fet driver control with an apb master
// assumes zero-wait apb and the 4000-cycle charge pull-low of the header
`timescale 1ns/1ps
`include "pfd_cfg.svh"
`define CMP(n, e, g) begin exp_q.push_back(32'(e)); obs_q.push_back(32'(g)); nm_q.push_back(n); end

module pfd_fet_ctrl_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    pfd_pkg::pfd_fault_s fault_in;
    logic charger_present, cc_valid, rd_err, dsg_fet_on, chg_fet_on;
    logic signed [15:0] cc_sample;
    logic discharge_gate_drive, charge_gate_drive, charge_gate_oe_n, dsg_ocd_enable;
    logic [31:0] exp_q[$]; // expected notes, oldest first
    logic [31:0] obs_q[$];
    string nm_q[$];
    int err_total, n_compared, n, hd, hc;
    logic [10:0] fen_v, flt_v;
    // cfg, fault, current, expected dsg and chg
    logic [31:0] bd_tab[6] = '{32'h61010003, 32'h61ff0001, 32'h61002001,
        32'h41010001, 32'h62ff0003, 32'h62010002};

    pfd_fet_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fault_in(fault_in), .charger_present(charger_present),
        .cc_sample(cc_sample), .cc_valid(cc_valid), .discharge_gate_drive(discharge_gate_drive),
        .charge_gate_drive(charge_gate_drive), .charge_gate_oe_n(charge_gate_oe_n),
        .dsg_ocd_enable(dsg_ocd_enable));
    pfd_fet_model i_fets (.dsg_drive(discharge_gate_drive), .chg_drive(charge_gate_drive),
        .chg_oe_n(charge_gate_oe_n), .dsg_fet_on(dsg_fet_on), .chg_fet_on(chg_fet_on));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask

    // one apb transfer; no cycle count assumed, only the watchdog ends a wait
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CMP($sformatf("reg %h", a), e, rd_data)
    endtask

    // flags and one current sample, then time for the two-flop sync
    task drv(input logic [10:0] f, input logic [15:0] c);
        @(posedge pclk);
        fault_in <= pfd_pkg::pfd_fault_s'(f);
        cc_sample <= c;
        cc_valid <= 1'b1;
        @(posedge pclk);
        cc_valid <= 1'b0;
        cyc(6);
    endtask

    task gates(input logic d, input logic c);
        `CMP("dsg", d, discharge_gate_drive)
        `CMP("dsg fet", d, dsg_fet_on)
        `CMP("chg", c, charge_gate_drive)
        `CMP("ocd", d, dsg_ocd_enable)
    endtask

    // high cycles over ten whole pwm periods
    task pwm_count;
        hd = 0;
        hc = 0;
        repeat (40) begin
            @(posedge pclk);
            hd += (discharge_gate_drive === 1'b1);
            hc += (charge_gate_drive === 1'b1);
        end
    endtask

    task summarize;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // monitor: oldest note against oldest observation
    initial begin
        forever begin
            wait (obs_q.size() > 0);
            n_compared++;
            if (obs_q[0] !== exp_q[0]) begin
                err_total++;
                $display("CHECK FAILED %s expected %h seen %h", nm_q[0], exp_q[0], obs_q[0]);
            end
            void'(obs_q.pop_front());
            void'(exp_q.pop_front());
            void'(nm_q.pop_front());
        end
    end

    // watchdog, well above the pull-low and the rest of the run
    initial begin
        cyc(30000);
        err_total++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        fault_in = '0;
        {charger_present, cc_valid, cc_sample, presetn} = '0;
        err_total = 0;
        n_compared = 0;
        void'($urandom(32'h2f8acd46));
        cyc(12);
        presetn <= 1'b1;
        @(posedge pclk);
        gates(1'b0, 1'b0);
        `CMP("oe_n", 0, charge_gate_oe_n)
        rd(`PFD_OFF_CTRL, 32'h00);
        rd(`PFD_OFF_CFG, 32'h02);
        rd(`PFD_OFF_FEN, 32'h7ff);
        rd(`PFD_OFF_BDT, 32'h40);
        rd(`PFD_OFF_PWM, 32'h8080ff);
        rd(8'h40, 32'h0);
        `CMP("slverr", 1, rd_err)
        drv(11'h000, 16'h0100);
        drv(11'h000, 16'h0100);
        rd(`PFD_OFF_CUR, 32'h100);
        rd(`PFD_OFF_FLT1, 32'hc0);
        rd(`PFD_OFF_FLT2, 32'h1f);
        rd(`PFD_OFF_ACC, 32'h200);
        apb(1'b1, `PFD_OFF_CUR, 32'h0);
        rd(`PFD_OFF_CUR, 32'h100);
        apb(1'b1, `PFD_OFF_CFG, 32'h3);
        apb(1'b1, `PFD_OFF_CTRL, 32'h18);
        cyc(4);
        gates(1'b0, 1'b0);
        apb(1'b1, `PFD_OFF_CFG, 32'h2);
        apb(1'b1, `PFD_OFF_CTRL, 32'h1);
        cyc(3);
        gates(1'b1, 1'b1);
        for (int i = 0; i < 8; i++) begin
            fen_v = $urandom;
            flt_v = $urandom;
            apb(1'b1, `PFD_OFF_FEN, {21'h0, fen_v});
            drv(flt_v, 16'h0100);
            gates(!(|(flt_v & fen_v & 11'h6cd)), !(|(flt_v & fen_v & 11'h732)));
        end
        apb(1'b1, `PFD_OFF_FEN, 32'h7ff);
        drv(11'h000, 16'h0100);
        apb(1'b1, `PFD_OFF_CTRL, 32'h1f);
        cyc(3);
        gates(1'b0, 1'b0);
        apb(1'b1, `PFD_OFF_CFG, 32'h3);
        cyc(3);
        gates(1'b1, 1'b1);
        apb(1'b1, `PFD_OFF_CFG, 32'h2);
        apb(1'b1, `PFD_OFF_CTRL, 32'h5);
        n = 0;
        while (charge_gate_oe_n !== 1'b1 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        `CMP("pull", 1, n >= 3998 && n <= 4004)
        `CMP("pin", 0, chg_fet_on)
        gates(1'b1, 1'b0);
        apb(1'b1, `PFD_OFF_CTRL, 32'h3);
        cyc(3);
        gates(1'b0, 1'b1);
        apb(1'b1, `PFD_OFF_CTRL, 32'h1);
        foreach (bd_tab[i]) begin
            apb(1'b1, `PFD_OFF_CFG, {29'h0, bd_tab[i][30:28]});
            drv({7'h0, bd_tab[i][27:24]}, bd_tab[i][23:8]);
            gates(bd_tab[i][1], bd_tab[i][0]);
        end
        apb(1'b1, `PFD_OFF_CFG, 32'h2);
        drv(11'h000, 16'h0000);
        apb(1'b1, `PFD_OFF_PWM, 32'h010203);
        apb(1'b1, `PFD_OFF_CTRL, 32'h61);
        charger_present <= 1'b1;
        cyc(8);
        pwm_count();
        `CMP("dsg pwm", 20, hd)
        `CMP("chg steady", 40, hc)
        charger_present <= 1'b0;
        cyc(8);
        pwm_count();
        `CMP("chg pwm", 10, hc)
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        @(posedge pclk);
        gates(1'b0, 1'b0);
        rd(`PFD_OFF_CTRL, 32'h00);
        cyc(2);
        summarize();
    end
endmodule

// ==== tb/pfd_fet_model.sv ====
// model of the external charge and discharge nfets on the gate pins
// assumes the gate-source resistor pulls a released charge gate low
`timescale 1ns/1ps

module pfd_fet_model (
    // gate driver pins
    input wire logic dsg_drive,
    input wire logic chg_drive,
    input wire logic chg_oe_n,
    // fet conduction
    output logic dsg_fet_on,
    output logic chg_fet_on
);
    // discharge pin is driven both ways, so the gate simply follows it
    assign dsg_fet_on = dsg_drive;
    // a released pin never shows the last level, the resistor wins
    assign chg_fet_on = chg_oe_n ? 1'b0 : chg_drive;
endmodule
